// *** rtl/ivm_mapper.sv ***
/*
 * Interrupt vector mapper: per-vector source attributes, request flags,
 * enables, routing to processor or transfer controller, wake request and
 * vector slot addresses for interrupts and traps.
 * Assumes request_in comes from outside this clock; controls and trap
 * strobes come from logic on clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ivm_defs.svh"

module ivm_mapper (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [31:0] vector_table_base,
	input wire logic [255:0] request_in,
	input wire logic [7:0] pin_level_mode,
	input wire logic enable_wr,
	input wire logic [4:0] enable_index,
	input wire logic [7:0] enable_data,
	output logic [7:0] enable_rdata,
	input wire logic transfer_enable_wr,
	input wire logic [7:0] transfer_enable_vector,
	input wire logic transfer_enable_data,
	input wire logic priority_wr,
	input wire logic [7:0] priority_index,
	input wire logic [`IVM_PRIO_WIDTH-1:0] priority_data,
	input wire logic breakpoint_instruction,
	input wire logic software_instruction,
	input wire logic [7:0] software_operand,
	output logic trap_valid,
	output logic [7:0] trap_vector,
	output logic [31:0] trap_vector_addr,
	output logic cpu_req,
	output logic [7:0] cpu_vector,
	output logic [31:0] cpu_vector_addr,
	output logic [`IVM_PRIO_WIDTH-1:0] cpu_priority,
	input wire logic cpu_ack,
	output logic transfer_req,
	output logic [7:0] transfer_vector,
	input wire logic transfer_ack,
	output logic wake_req
);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------

	// Fixed attributes of a vector slot
	function automatic ivm_pkg::ivm_attr_t src_attr(input logic [7:0] v, input logic [7:0] pin_lvl);
		ivm_pkg::ivm_attr_t a;
		a = '0;
		a.prio_index = v;
		if (v <= `IVM_VEC_TRAP_LAST) begin
			a = '0;
		end else if (v >= `IVM_VEC_PIN_FIRST && v <= `IVM_VEC_PIN_LAST) begin
			a = '{1'b1, pin_lvl[v[2:0]], 1'b1, 1'b1, 1'b1, v};
		end else begin
			case (v)
				`IVM_VEC_BUS_ERROR: a = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, v};
				`IVM_VEC_SOFTWARE, `IVM_VEC_COMPARE_A, `IVM_VEC_COMPARE_B,
				`IVM_VEC_BUS_FIFO_A, `IVM_VEC_BUS_FIFO_B:
					a = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, v};
				`IVM_VEC_BUS_STATUS: a = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, v};
				`IVM_VEC_SERIAL_ERROR, `IVM_VEC_DATA_COMPARE:
					a = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, v};
				`IVM_VEC_SERIAL_RX, `IVM_VEC_SERIAL_TX:
					a = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, `IVM_VEC_SERIAL_ERROR};
				`IVM_VEC_SERIAL_IDLE:
					a = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, `IVM_VEC_SERIAL_ERROR};
				`IVM_VEC_CLOCK_CARRY: a = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, v};
				`IVM_VEC_MONITOR_ONE, `IVM_VEC_MONITOR_TWO:
					a = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, v};
				`IVM_VEC_BUS_RESUME: a = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, v};
				`IVM_VEC_CLOCK_ALARM, `IVM_VEC_CLOCK_PERIODIC:
					a = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, v};
				`IVM_VEC_CONVERTER_END, `IVM_VEC_CONVERTER_GROUP, `IVM_VEC_EVENT_LINK:
					a = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, v};
				default: begin
					if (v >= `IVM_VEC_CLOCK_CHECK_FIRST && v <= `IVM_VEC_CLOCK_CHECK_LAST) begin
						a = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, v};
					end else if (v >= `IVM_VEC_TIMER0_MATCH && v <= `IVM_VEC_TIMER0_MATCH_LAST) begin
						a = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, `IVM_VEC_TIMER0_MATCH};
					end else if (v >= `IVM_VEC_TIMER0_OTHER && v <= `IVM_VEC_TIMER0_OTHER_LAST) begin
						a = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, `IVM_VEC_TIMER0_OTHER};
					end else if (v >= `IVM_VEC_TIMER1_MATCH && v <= `IVM_VEC_TIMER1_MATCH_LAST) begin
						a = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, `IVM_VEC_TIMER1_MATCH};
					end else if (v >= `IVM_VEC_TIMER1_OTHER && v <= `IVM_VEC_TIMER1_OTHER_LAST) begin
						a = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, `IVM_VEC_TIMER1_OTHER};
					end else if (v >= `IVM_VEC_TIMER2_MATCH && v <= `IVM_VEC_TIMER2_MATCH_LAST) begin
						a = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, `IVM_VEC_TIMER2_MATCH};
					end else if (v >= `IVM_VEC_TIMER2_OTHER && v <= `IVM_VEC_TIMER2_OTHER_LAST) begin
						a = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, `IVM_VEC_TIMER2_OTHER};
					end else begin
						a = '0;
					end
				end
			endcase
		end
		return a;
	endfunction

	// slot address, low base bits ignored
	function automatic logic [31:0] slot_addr(input logic [31:0] base, input logic [7:0] v);
		// offset is four times the vector
		return {base[31:2], 2'b00} + {22'h000000, v, 2'b00};
	endfunction

	function automatic logic [8:0] find_lowest(input logic [255:0] bits);
		logic [8:0] r;
		r = 9'h000;
		for (int i = 255; i >= 0; i--) begin
			if (bits[i]) begin
				r = {1'b1, 8'(i)};
			end
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Reset release and input synchronisers
	// ---------------------------------------------------------------
	logic rst_sync_n;
	logic [255:0] request_sync;

	ivm_sync #(.WIDTH(1)) u_rst_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in(1'b1),
		.sync_out(rst_sync_n)
	);

	ivm_sync #(.WIDTH(256)) u_req_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_sync_n),
		.async_in(request_in),
		.sync_out(request_sync)
	);

	// ---------------------------------------------------------------
	// Attribute table
	// ---------------------------------------------------------------
	ivm_pkg::ivm_attr_t attr [256];

	always_comb begin
		for (int i = 0; i < 256; i++) begin
			attr[i] = src_attr(8'(i), pin_level_mode);
		end
	end

	// ---------------------------------------------------------------
	// State update
	// ---------------------------------------------------------------
	ivm_pkg::ivm_state_t st;
	ivm_pkg::ivm_state_t next_st;
	logic [255:0] cpu_cand;
	logic [255:0] xfer_cand;
	logic [255:0] clr;
	logic [8:0] cpu_win;
	logic [8:0] xfer_win;
	logic [7:0] prio_rd_index;
	logic prio_wr_ok;

	always_comb begin
		next_st = st;
		clr = '0;
		if (cpu_ack && st.cpu_req) begin
			clr[st.cpu_vector] = 1'b1;
		end
		if (transfer_ack && st.xfer_req) begin
			clr[st.xfer_vector] = 1'b1;
		end
		cpu_cand = '0;
		xfer_cand = '0;
		for (int i = 0; i < 256; i++) begin
			// detection fixed per source, pins chosen by pin_level_mode; set wins over clear
			if (!attr[i].mapped) begin
				next_st.flag[i] = 1'b0;
			end else if (attr[i].level) begin
				next_st.flag[i] = request_sync[i];
			end else begin
				next_st.flag[i] = (st.flag[i] & ~clr[i]) | (request_sync[i] & ~st.prev_in[i]);
			end
			// transfer only where usable and enabled
			xfer_cand[i] = st.flag[i] & st.req_en[i] & attr[i].xfer_ok & st.xfer_en[i] & ~clr[i];
			cpu_cand[i] = st.flag[i] & st.req_en[i] & attr[i].cpu & ~xfer_cand[i] & ~clr[i];
		end
		next_st.prev_in = request_sync;

		// enable register v/8, bit v mod 8
		if (enable_wr) begin
			for (int b = 0; b < 8; b++) begin
				next_st.req_en[{enable_index, 3'(b)}] =
					enable_data[b] & attr[{enable_index, 3'(b)}].mapped;
			end
		end
		next_st.enable_rdata = st.req_en[{enable_index, 3'b000} +: 8];
		// transfer enable numbered as the vector
		if (transfer_enable_wr) begin
			next_st.xfer_en[transfer_enable_vector] =
				transfer_enable_data & attr[transfer_enable_vector].xfer_ok;
		end

		cpu_win = find_lowest(cpu_cand);
		xfer_win = find_lowest(xfer_cand);
		next_st.cpu_req = cpu_win[8];
		next_st.cpu_vector = cpu_win[7:0];
		next_st.cpu_addr = slot_addr(vector_table_base, cpu_win[7:0]);
		next_st.xfer_req = xfer_win[8];
		next_st.xfer_vector = xfer_win[7:0];

		next_st.wake_req = 1'b0;
		for (int i = 0; i < 256; i++) begin
			next_st.wake_req = next_st.wake_req | (st.flag[i] & st.req_en[i] & attr[i].wake);
		end

		// breakpoint uses vector 0; any operand
		next_st.trap_valid = breakpoint_instruction | software_instruction;
		next_st.trap_vector = breakpoint_instruction ? `IVM_VEC_BREAKPOINT : software_operand;
		next_st.trap_addr = slot_addr(vector_table_base, next_st.trap_vector);
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// Priority registers
	// ---------------------------------------------------------------
	// only the group's own register is writable
	assign prio_wr_ok = priority_wr && attr[priority_index].mapped
		&& attr[priority_index].prio_index == priority_index;
	assign prio_rd_index = attr[cpu_win[7:0]].prio_index;

	ivm_prio_mem u_prio_mem (
		.clk_sys(clk_sys),
		.rst_n(rst_sync_n),
		.wr_en(prio_wr_ok),
		.wr_index(priority_index),
		.wr_data(priority_data),
		.rd_index(prio_rd_index),
		.rd_data(cpu_priority)
	);

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign enable_rdata = st.enable_rdata;
	assign trap_valid = st.trap_valid;
	assign trap_vector = st.trap_vector;
	assign trap_vector_addr = st.trap_addr;
	assign cpu_req = st.cpu_req;
	assign cpu_vector = st.cpu_vector;
	assign cpu_vector_addr = st.cpu_addr;
	assign transfer_req = st.xfer_req;
	assign transfer_vector = st.xfer_vector;
	assign wake_req = st.wake_req;

endmodule

`default_nettype wire

// *** rtl/ivm_defs.svh ***
/*
 * Constants of the interrupt vector mapper: table geometry, vector numbers
 * and reset values.
 * Assumes nothing; included by its bare name.
 */
`ifndef IVM_DEFS_SVH
`define IVM_DEFS_SVH

// ---------------------------------------------------------------
// Table geometry
// ---------------------------------------------------------------
`define IVM_VECTOR_COUNT 256
`define IVM_TABLE_BYTES 1024
`define IVM_SLOT_SHIFT 2
`define IVM_ENABLE_REGS 32
`define IVM_PRIO_WIDTH 4

// ---------------------------------------------------------------
// Vector numbers
// ---------------------------------------------------------------
`define IVM_VEC_BREAKPOINT 8'h00
`define IVM_VEC_TRAP_LAST 8'h0F
`define IVM_VEC_BUS_ERROR 8'h10
`define IVM_VEC_SOFTWARE 8'h1B
`define IVM_VEC_COMPARE_A 8'h1C
`define IVM_VEC_COMPARE_B 8'h1D
`define IVM_VEC_CLOCK_CHECK_FIRST 8'h20
`define IVM_VEC_CLOCK_CHECK_LAST 8'h22
`define IVM_VEC_BUS_FIFO_A 8'h24
`define IVM_VEC_BUS_FIFO_B 8'h25
`define IVM_VEC_BUS_STATUS 8'h26
`define IVM_VEC_SERIAL_ERROR 8'h2C
`define IVM_VEC_SERIAL_RX 8'h2D
`define IVM_VEC_SERIAL_TX 8'h2E
`define IVM_VEC_SERIAL_IDLE 8'h2F
`define IVM_VEC_DATA_COMPARE 8'h39
`define IVM_VEC_CLOCK_CARRY 8'h3F
`define IVM_VEC_PIN_FIRST 8'h40
`define IVM_VEC_PIN_LAST 8'h47
`define IVM_VEC_MONITOR_ONE 8'h58
`define IVM_VEC_MONITOR_TWO 8'h59
`define IVM_VEC_BUS_RESUME 8'h5A
`define IVM_VEC_CLOCK_ALARM 8'h5C
`define IVM_VEC_CLOCK_PERIODIC 8'h5D
`define IVM_VEC_CONVERTER_END 8'h66
`define IVM_VEC_CONVERTER_GROUP 8'h67
`define IVM_VEC_EVENT_LINK 8'h6A
`define IVM_VEC_TIMER0_MATCH 8'h72
`define IVM_VEC_TIMER0_MATCH_LAST 8'h75
`define IVM_VEC_TIMER0_OTHER 8'h76
`define IVM_VEC_TIMER0_OTHER_LAST 8'h78
`define IVM_VEC_TIMER1_MATCH 8'h79
`define IVM_VEC_TIMER1_MATCH_LAST 8'h7A
`define IVM_VEC_TIMER1_OTHER 8'h7B
`define IVM_VEC_TIMER1_OTHER_LAST 8'h7C
`define IVM_VEC_TIMER2_MATCH 8'h7D
`define IVM_VEC_TIMER2_MATCH_LAST 8'h7E
`define IVM_VEC_TIMER2_OTHER 8'h7F
`define IVM_VEC_TIMER2_OTHER_LAST 8'h80

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define IVM_RST_PRIORITY 4'h0

`endif

// *** rtl/ivm_pkg.sv ***
/*
 * Types of the interrupt vector mapper.
 * Assumes ivm_defs.svh is on the include path.
 */
`include "ivm_defs.svh"

package ivm_pkg;

	// Fixed properties of one vector slot
	typedef struct packed {
		logic mapped;
		logic level;
		logic cpu;
		logic xfer_ok;
		logic wake;
		logic [7:0] prio_index;
	} ivm_attr_t;

	typedef struct packed {
		logic [255:0] flag;
		logic [255:0] prev_in;
		logic [255:0] req_en;
		logic [255:0] xfer_en;
		logic cpu_req;
		logic [7:0] cpu_vector;
		logic [31:0] cpu_addr;
		logic xfer_req;
		logic [7:0] xfer_vector;
		logic wake_req;
		logic trap_valid;
		logic [7:0] trap_vector;
		logic [31:0] trap_addr;
		logic [7:0] enable_rdata;
	} ivm_state_t;

endpackage

// *** rtl/ivm_sync.sv ***
/*
 * Two-flop synchroniser of a bus of independent levels.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/100ps
`default_nettype none

module ivm_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stage <= '0;
			sync_out <= '0;
		end else begin
			stage <= async_in;
			sync_out <= stage;
		end
	end

endmodule

`default_nettype wire

// *** rtl/ivm_prio_mem.sv ***
/*
 * Priority register store: one word per vector, registered read.
 * Assumes a single clock and a synchronous write port.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ivm_defs.svh"

module ivm_prio_mem (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [7:0] wr_index,
	input wire logic [`IVM_PRIO_WIDTH-1:0] wr_data,
	input wire logic [7:0] rd_index,
	output logic [`IVM_PRIO_WIDTH-1:0] rd_data
);

	logic [`IVM_PRIO_WIDTH-1:0] mem [`IVM_VECTOR_COUNT];

	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_index] <= wr_data;
		end
	end

	// Unwritten words read as the reset priority
	logic [255:0] written;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			written <= '0;
			rd_data <= `IVM_RST_PRIORITY;
		end else begin
			if (wr_en) begin
				written[wr_index] <= 1'b1;
			end
			rd_data <= written[rd_index] ? mem[rd_index] : `IVM_RST_PRIORITY;
		end
	end

endmodule

`default_nettype wire

// *** verif/ivm_mapper_properties.sv ***
/*
 * Port checker of the interrupt vector mapper, bound onto its top module.
 * Assumes one clock domain and the active-low asynchronous reset rst_n.
 */
`timescale 1ns/100ps
`default_nettype none

module ivm_mapper_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [31:0] vector_table_base,
	input wire logic [7:0] pin_level_mode,
	input wire logic breakpoint_instruction,
	input wire logic software_instruction,
	input wire logic [7:0] software_operand,
	input wire logic trap_valid,
	input wire logic [7:0] trap_vector,
	input wire logic [31:0] trap_vector_addr,
	input wire logic cpu_req,
	input wire logic [7:0] cpu_vector,
	input wire logic [31:0] cpu_vector_addr,
	input wire logic cpu_ack,
	input wire logic transfer_req,
	input wire logic [7:0] transfer_vector,
	input wire logic wake_req
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire logic [31:0] base_al = {vector_table_base[31:2], 2'h0};

	chk_breakpoint_vector:
	assert property (breakpoint_instruction |=> trap_valid && trap_vector == 8'h00)
		else $error("breakpoint trap not through vector 0");
	chk_soft_vector:
	assert property (software_instruction && !breakpoint_instruction |=>
		trap_valid && trap_vector == $past(software_operand))
		else $error("software trap vector differs from operand");
	chk_trap_cause:
	assert property (trap_valid |-> $past(breakpoint_instruction) || $past(software_instruction))
		else $error("trap without instruction");
	chk_trap_addr:
	assert property (trap_valid |-> trap_vector_addr == base_al + {22'h0, trap_vector, 2'h0})
		else $error("trap slot address wrong");
	chk_cpu_addr:
	assert property (cpu_req |-> cpu_vector_addr == base_al + {22'h0, cpu_vector, 2'h0})
		else $error("interrupt slot address wrong");
	chk_cpu_mapped:
	assert property (cpu_req |-> cpu_vector > 8'h0F)
		else $error("interrupt through a trap vector");
	chk_xfer_capable:
	assert property (transfer_req |->
		!(transfer_vector inside {[8'h00:8'h1A], 8'h3F, [8'h58:8'h5D]}))
		else $error("transfer from a source that cannot start one");
	chk_edge_ack:
	assert property (cpu_req && cpu_ack && cpu_vector inside {[8'h40:8'h47]} &&
		!pin_level_mode[cpu_vector[2:0]] |=> !cpu_req || cpu_vector != $past(cpu_vector))
		else $error("edge request survives its acknowledge");
	chk_reset_quiet:
	assert property ($rose(rst_n) |-> !cpu_req && !transfer_req && !trap_valid && !wake_req)
		else $error("request out of reset");
endmodule

bind ivm_mapper ivm_mapper_chk u_chk (.clk_sys, .rst_n, .vector_table_base, .pin_level_mode,
	.breakpoint_instruction, .software_instruction, .software_operand, .trap_valid,
	.trap_vector, .trap_vector_addr, .cpu_req, .cpu_vector, .cpu_vector_addr, .cpu_ack,
	.transfer_req, .transfer_vector, .wake_req);

`default_nettype wire

// *** verif/ivm_core_model.sv ***
/*
 * Processor core model: acknowledges interrupt and transfer requests.
 * Assumes requests stand until acknowledged; ack_delay sets promptness.
 */
`timescale 1ns/100ps
`default_nettype none

module ivm_core_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [3:0] ack_delay,
	input wire logic cpu_req,
	input wire logic transfer_req,
	output logic cpu_ack,
	output logic transfer_ack
);
	logic [3:0] wait_cpu;
	logic [3:0] wait_xfer;

	// One-cycle acknowledge after the chosen wait
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cpu_ack <= 1'b0;
			transfer_ack <= 1'b0;
			wait_cpu <= 4'h0;
			wait_xfer <= 4'h0;
		end else begin
			cpu_ack <= cpu_req && !cpu_ack && wait_cpu >= ack_delay;
			transfer_ack <= transfer_req && !transfer_ack && wait_xfer >= ack_delay;
			wait_cpu <= (cpu_req && !cpu_ack && wait_cpu < ack_delay) ? wait_cpu + 4'h1 : 4'h0;
			wait_xfer <= (transfer_req && !transfer_ack && wait_xfer < ack_delay) ?
				wait_xfer + 4'h1 : 4'h0;
		end
	end
endmodule

`default_nettype wire

// *** verif/ivm_mapper_tb.sv ***
/*
 * Self-checking bench of the interrupt vector mapper with a core model.
 * Assumes the mapper, its checker and the core model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module ivm_mapper_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] base = 32'h0;
	logic [255:0] req = '0;
	logic en_wr = 1'b0, te_wr = 1'b0, pr_wr = 1'b0, te_dat = 1'b0;
	logic bkpt = 1'b0, swi = 1'b0, wake_seen = 1'b0;
	logic [1:0] lvl_seen = 2'h0;
	logic [7:0] pin_lvl = 8'h00;
	logic [4:0] en_idx = 5'h00;
	logic [7:0] en_dat = 8'h00, te_vec = 8'h00, pr_idx = 8'h00, sw_op = 8'h00;
	logic [3:0] pr_dat = 4'h0, dly = 4'h0;
	logic [7:0] enable_rdata, trap_vector, cpu_vector, transfer_vector;
	logic [31:0] trap_vector_addr, cpu_vector_addr;
	logic [3:0] cpu_priority;
	logic trap_valid, cpu_req, cpu_ack, transfer_req, transfer_ack, wake_req;
	logic [31:0] seed = 32'h0000006D;
	logic [43:0] q_cpu [$], q_xfer [$], q_trap [$];
	logic [3:0] pexp [256] = '{default: 4'h0};
	logic [4:0] eidx [8] = '{5'h01, 5'h02, 5'h03, 5'h08, 5'h0B, 5'h0C, 5'h0D, 5'h0E};
	logic [7:0] emask [8] = '{8'h00, 8'h01, 8'h38, 8'hFF, 8'h37, 8'hC0, 8'h04, 8'hFC};
	int fails = 0;
	int num_checks = 0;

	ivm_mapper uut (.clk_sys, .rst_n, .vector_table_base(base), .request_in(req),
		.pin_level_mode(pin_lvl), .enable_wr(en_wr), .enable_index(en_idx),
		.enable_data(en_dat), .enable_rdata, .transfer_enable_wr(te_wr),
		.transfer_enable_vector(te_vec), .transfer_enable_data(te_dat),
		.priority_wr(pr_wr), .priority_index(pr_idx), .priority_data(pr_dat),
		.breakpoint_instruction(bkpt), .software_instruction(swi), .software_operand(sw_op),
		.trap_valid, .trap_vector, .trap_vector_addr, .cpu_req, .cpu_vector,
		.cpu_vector_addr, .cpu_priority, .cpu_ack, .transfer_req, .transfer_vector,
		.transfer_ack, .wake_req);
	ivm_core_model core (.clk_sys, .rst_n, .ack_delay(dly), .cpu_req, .transfer_req,
		.cpu_ack, .transfer_ack);

	initial forever #2.5 clk_sys = ~clk_sys;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic chk(input string what, input logic [43:0] e, input logic [43:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic pop(ref logic [43:0] q [$], input string what, input logic [43:0] g);
		chk(what, q.size() != 0 ? q.pop_front() : ~g, g);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic rst();
		rst_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask

	// Kind 0 enable, 1 transfer enable, 2 priority
	task automatic wr(input logic [1:0] k, input logic [7:0] i, input logic [7:0] d);
		@(posedge clk_sys);
		en_wr <= k == 2'h0;
		te_wr <= k == 2'h1;
		pr_wr <= k == 2'h2;
		en_idx <= i[4:0];
		te_vec <= i;
		pr_idx <= i;
		en_dat <= d;
		te_dat <= d[0];
		pr_dat <= d[3:0];
		@(posedge clk_sys);
		{en_wr, te_wr, pr_wr} <= 3'h0;
	endtask

	task automatic rd(input logic [4:0] i, input logic [7:0] e);
		@(posedge clk_sys);
		en_idx <= i;
		repeat (3) @(posedge clk_sys);
		chk("enable_rdata", {36'h0, e}, {36'h0, enable_rdata});
	endtask

	task automatic trap(input logic b, input logic s, input logic [7:0] op);
		@(posedge clk_sys);
		bkpt <= b;
		swi <= s;
		sw_op <= op;
		q_trap.push_back({4'h0, b ? 8'h00 : op, base + {22'h0, b ? 8'h00 : op, 2'h0}});
		@(posedge clk_sys);
		bkpt <= 1'b0;
		swi <= 1'b0;
	endtask

	// Call at a clock edge; expectations pushed in vector order
	task automatic raise(input logic [7:0] v, input logic x);
		req[v] <= 1'b1;
		if (x)
			q_xfer.push_back({36'h0, v});
		else
			q_cpu.push_back({pexp[v], v, base + {22'h0, v, 2'h0}});
	endtask

	task automatic drain();
		int n = 0;
		while ((q_cpu.size() + q_xfer.size() + q_trap.size()) != 0 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk("pending", 44'h0, {41'h0, q_cpu.size() != 0, q_xfer.size() != 0, q_trap.size() != 0});
		repeat (6) @(posedge clk_sys);
		req <= '0;
		repeat (4) @(posedge clk_sys);
	endtask

	// Result watcher: every result takes the oldest note of its kind
	always @(posedge clk_sys) begin
		if (wake_req === 1'b1)
			wake_seen = 1'b1;
		if (cpu_req === 1'b1 && cpu_vector === 8'h10)
			lvl_seen[0] = 1'b1;
		if (cpu_req === 1'b1 && cpu_vector === 8'h43)
			lvl_seen[1] = 1'b1;
		if (trap_valid === 1'b1)
			pop(q_trap, "trap", {4'h0, trap_vector, trap_vector_addr});
		if (cpu_req === 1'b1 && cpu_ack === 1'b1)
			pop(q_cpu, "cpu", {cpu_priority, cpu_vector, cpu_vector_addr});
		if (transfer_req === 1'b1 && transfer_ack === 1'b1)
			pop(q_xfer, "transfer", {36'h0, transfer_vector});
	end

	// Whole run takes about 200 cycles; allow thirty-five times that
	initial begin
		#35000;
		fails++;
		final_report();
	end

	initial begin
		rst();
		seed = xs(seed);
		// aligned base, loaded before any enable
		base <= seed & 32'hFFFF_FFFC;
		trap(1'b1, 1'b0, 8'h00);
		trap(1'b1, 1'b1, 8'h55);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			trap(1'b0, 1'b1, k == 0 ? 8'h00 : k == 1 ? 8'hFF : seed[7:0]);
		end
		drain();
		$display("test traps done");
		foreach (eidx[k])
			wr(2'h0, {3'h0, eidx[k]}, 8'hFF);
		foreach (eidx[k])
			rd(eidx[k], emask[k]);
		$display("test enables done");
		seed = xs(seed);
		pexp[64] = seed[3:0] | 4'h1;
		wr(2'h2, 8'h40, {4'h0, pexp[64]});
		pexp[114:117] = '{4'hA, 4'hA, 4'hA, 4'hA};
		wr(2'h2, 8'h72, 8'h0A);
		wr(2'h2, 8'h75, 8'h03);
		wr(2'h1, 8'h66, 8'h01);
		wr(2'h1, 8'h42, 8'h01);
		wr(2'h1, 8'h58, 8'h01);
		@(posedge clk_sys);
		req[8'h05] <= 1'b1;
		raise(8'h1B, 1'b0);
		raise(8'h66, 1'b1);
		raise(8'h6A, 1'b0);
		raise(8'h73, 1'b0);
		drain();
		chk("wake", 44'h0, {43'h0, wake_seen});
		$display("test prompt routing done");
		dly <= 4'h3;
		pin_lvl <= 8'h08;
		@(posedge clk_sys);
		raise(8'h40, 1'b0);
		raise(8'h41, 1'b0);
		raise(8'h42, 1'b1);
		raise(8'h58, 1'b0);
		raise(8'h5D, 1'b0);
		drain();
		chk("wake", 44'h1, {43'h0, wake_seen});
		$display("test slow routing done");
		// Level sources: offered while high, withdrawn before the slow core acknowledges
		for (int k = 0; k < 2; k++) begin
			req[k == 0 ? 8'h10 : 8'h43] <= 1'b1;
			@(posedge clk_sys);
			req <= '0;
			repeat (8) @(posedge clk_sys);
		end
		chk("level", 44'h3, {42'h0, lvl_seen});
		$display("test level sources done");
		rst();
		trap(1'b0, 1'b1, 8'h2A);
		drain();
		$display("test second reset done");
		final_report();
	end
endmodule

`default_nettype wire
